/* File: verilog/mpc_consts.vh */
/*
 * Constants for the module power control block: power states, loss policy codes,
 * sleep codes and timing figures.
 * Assumes a single 40 MHz standby clock.
 */
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

`define MPC_CLK_HZ            40000000
// Power state machine
`define MPC_ST_OFF            3'h0
`define MPC_ST_WAIT_GOOD      3'h1
`define MPC_ST_RUN            3'h2
`define MPC_ST_SLEEP          3'h3
`define MPC_ST_DEEP           3'h4
`define MPC_ST_W              3
// Loss policy codes
`define MPC_POL_ALWAYS_ON     2'h0
`define MPC_POL_REMAIN_OFF    2'h1
`define MPC_POL_LAST_STATE    2'h2
// Sleep kind codes
`define MPC_SX_S3             2'h0
`define MPC_SX_S4             2'h1
`define MPC_SX_S5             2'h2
// Minimum wait before entering deep state from a sleep state
`define MPC_DEEP_DELAY_MS     1
`define MPC_CNT_W             24
`define MPC_CNT_ZERO          24'h000000
`define MPC_CNT_ONE           24'h000001
`define MPC_MS_PER_S          1000
// Reset levels of flops and synchronisers
`define MPC_OFF_N             1'b1
`define MPC_RESET_ASSERT      1'b0
`define MPC_FLAG_CLEAR        1'b0
`define MPC_FLAG_SET          1'b1
`define MPC_BTN_IDLE_N        1'b1
`define MPC_PG_SYNC_RESET     1'b0

`endif

/* File: verilog/mpc_sync2.v */
/*
 * Two-stage level synchroniser.
 * Assumes the input is a slow level from off-chip; reset value is a parameter.
 */
`timescale 1ns/1ps
`default_nettype none

module mpc_sync2 #(
	parameter [0:0] RESET_VAL = 1'b0
) (
	input  wire ref_clk_in,
	input  wire reset_in,
	input  wire async_in,
	output reg  sync_out
);
	reg meta_q;

	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			meta_q   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

`default_nettype wire

/* File: verilog/mpc_power_ctrl.v */
/*
 * Module power control: holds the module in reset while power is not good,
 * drives the active-low supply-on output, acts on the power button, applies the
 * AC loss policy and resumes from the deep low-power state into the sleep state
 * it came from.
 * Assumes a free-running standby clock and that reset_in marks AC power arrival.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_consts.vh"

// Functional notes
// - Power-good high allows onboard sequencing
// - Module held in reset while power-good low
// - Undriven power-good defaults to good level
// - Active-low sleep/supply-on output switches supply
// - Button press requests power on or off
// - Deep state keeps only limited wake logic
// - Deep wake returns to entry sleep state
// - AC loss policy: on, off, last state
module mpc_power_ctrl #(
	parameter DEEP_DELAY_CYCLES = (`MPC_DEEP_DELAY_MS * (`MPC_CLK_HZ / `MPC_MS_PER_S))
) (
	input  wire       ref_clk_in,
	input  wire       reset_in,
	input  wire       power_good_in,
	input  wire       power_button_n_in,
	input  wire [1:0] loss_policy_in,
	input  wire       last_state_on_in,
	input  wire       sleep_req_in,
	input  wire [1:0] sleep_kind_in,
	input  wire       deep_enable_in,
	input  wire       wake_event_in,
	output reg        sleep_supply_on_n_out,
	output reg        module_reset_n_out,
	output reg        sequencing_en_out,
	output reg        deep_low_power_state_out,
	output reg  [1:0] sleep_kind_out,
	output reg        power_state_on_out
);
	// State codes, and the deep delay cut to the counter width
	localparam [`MPC_ST_W-1:0]  ST_OFF       = `MPC_ST_OFF;
	localparam [`MPC_ST_W-1:0]  ST_WAIT_GOOD = `MPC_ST_WAIT_GOOD;
	localparam [`MPC_ST_W-1:0]  ST_RUN       = `MPC_ST_RUN;
	localparam [`MPC_ST_W-1:0]  ST_SLEEP     = `MPC_ST_SLEEP;
	localparam [`MPC_ST_W-1:0]  ST_DEEP      = `MPC_ST_DEEP;
	localparam [`MPC_CNT_W-1:0] DEEP_RELOAD  = DEEP_DELAY_CYCLES[`MPC_CNT_W-1:0];

	wire                  pg_sync;
	wire                  btn_n_sync;
	wire                  btn_press;
	wire                  next_run;
	wire                  next_wait;
	wire                  next_deep;
	reg                   btn_n_prev_q;
	reg                   boot_q;
	reg  [`MPC_ST_W-1:0]  state_q;
	reg  [`MPC_ST_W-1:0]  state_d;
	reg  [1:0]            sx_q;
	reg  [1:0]            sx_d;
	reg  [`MPC_CNT_W-1:0] cnt_q;
	reg  [`MPC_CNT_W-1:0] cnt_d;

	// Starts low so a stale level cannot release the module before the pin is
	// seen; an undriven pin reads good through the divider and still boots
	mpc_sync2 #(.RESET_VAL(`MPC_PG_SYNC_RESET)) u_pg_sync (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.async_in   (power_good_in),
		.sync_out   (pg_sync)
	);

	// Starts at the released level, so leaving reset never fakes a press
	mpc_sync2 #(.RESET_VAL(`MPC_BTN_IDLE_N)) u_btn_sync (
		.ref_clk_in (ref_clk_in),
		.reset_in   (reset_in),
		.async_in   (power_button_n_in),
		.sync_out   (btn_n_sync)
	);

	// Button is debounced on the carrier, so one falling edge is one press
	assign btn_press = btn_n_prev_q & ~btn_n_sync;

	// Next-state decodes shared by the output flops
	assign next_run  = (state_d == ST_RUN);
	assign next_wait = (state_d == ST_WAIT_GOOD);
	assign next_deep = (state_d == ST_DEEP);

	always @* begin
		state_d = state_q;
		sx_d    = sx_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_OFF: begin
				if (boot_q) begin
					// First decision after AC arrives follows the loss policy
					case (loss_policy_in)
						`MPC_POL_ALWAYS_ON:  state_d = ST_WAIT_GOOD;
						`MPC_POL_LAST_STATE: state_d = last_state_on_in ?
							ST_WAIT_GOOD : ST_OFF;
						default:             state_d = ST_OFF;
					endcase
				end else if (btn_press) begin
					state_d = ST_WAIT_GOOD;
				end
			end
			ST_WAIT_GOOD: begin
				if (btn_press)
					state_d = ST_OFF;
				else if (pg_sync)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (!pg_sync)
					state_d = ST_WAIT_GOOD;
				else if (btn_press)
					state_d = ST_OFF;
				else if (sleep_req_in) begin
					state_d = ST_SLEEP;
					sx_d    = sleep_kind_in;
					cnt_d   = DEEP_RELOAD;
				end
			end
			ST_SLEEP: begin
				if (btn_press || wake_event_in)
					state_d = ST_WAIT_GOOD;
				else if (deep_enable_in) begin
					if (cnt_q <= `MPC_CNT_ONE)
						state_d = ST_DEEP;
					else
						cnt_d = cnt_q - `MPC_CNT_ONE;
				end
			end
			ST_DEEP: begin
				// Only the button and the wake line are watched here
				if (btn_press || wake_event_in) begin
					state_d = ST_SLEEP;
					cnt_d   = DEEP_RELOAD;
				end
			end
			default: state_d = ST_OFF;
		endcase
	end

	// State, latched sleep kind, deep delay and the boot marker
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_q      <= ST_OFF;
			sx_q         <= `MPC_SX_S5;
			cnt_q        <= `MPC_CNT_ZERO;
			boot_q       <= `MPC_FLAG_SET;
			btn_n_prev_q <= `MPC_BTN_IDLE_N;
		end else begin
			state_q      <= state_d;
			sx_q         <= sx_d;
			cnt_q        <= cnt_d;
			boot_q       <= `MPC_FLAG_CLEAR;
			btn_n_prev_q <= btn_n_sync;
		end
	end

	// Outputs are registered from the next state, so they move on the same
	// edge as the state and no decode glitch reaches a pin

	// Supply is on while running or waiting for good; low means on
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			sleep_supply_on_n_out <= `MPC_OFF_N;
		end else begin
			sleep_supply_on_n_out <= ~(next_run | next_wait);
		end
	end

	// Gated by the synchronised pin too, so release never runs ahead of it
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			module_reset_n_out <= `MPC_RESET_ASSERT;
		end else begin
			module_reset_n_out <= next_run & pg_sync;
		end
	end

	// Onboard sequencing may only run once power is good
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			sequencing_en_out <= `MPC_FLAG_CLEAR;
		end else begin
			sequencing_en_out <= next_run;
		end
	end

	// Everything but the wake logic is off in the deep state
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			deep_low_power_state_out <= `MPC_FLAG_CLEAR;
		end else begin
			deep_low_power_state_out <= next_deep;
		end
	end

	// Kept through sleep and deep, so a deep wake lands in the entry kind
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			sleep_kind_out <= `MPC_SX_S5;
		end else begin
			sleep_kind_out <= sx_d;
		end
	end

	// Reported on state for a last-state policy kept outside this block
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			power_state_on_out <= `MPC_FLAG_CLEAR;
		end else begin
			power_state_on_out <= next_run;
		end
	end
endmodule

`default_nettype wire

/* File: bench/mpc_power_ctrl_asserts.sv */
/* Port checker for mpc_power_ctrl.
   Assumes it is bound to the top module and clocked by its standby clock. */
`timescale 1ns/1ps
`default_nettype none
module mpc_power_ctrl_asserts (
	input wire logic	ref_clk_in,
	input wire logic	reset_in,
	input wire logic	power_good_in,
	input wire logic	power_button_n_in,
	input wire logic [1:0]	loss_policy_in,
	input wire logic	last_state_on_in,
	input wire logic	sleep_supply_on_n_out,
	input wire logic	module_reset_n_out,
	input wire logic	sequencing_en_out,
	input wire logic	deep_low_power_state_out,
	input wire logic [1:0]	sleep_kind_out,
	input wire logic	power_state_on_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	chk_reset_hold: assert property (!power_good_in [*4] |-> !module_reset_n_out)
		else $error("reset released");
	chk_run_outs: assert property (module_reset_n_out |-> sequencing_en_out &&
		power_state_on_out && !sleep_supply_on_n_out) else $error("run outputs");
	chk_reset_sync: assert property ($rose(module_reset_n_out) |-> $past(power_good_in, 3))
		else $error("unsynchronised release");
	chk_button_off: assert property (power_state_on_out && $fell(power_button_n_in) |=>
		power_state_on_out ##[1:4] !power_state_on_out) else $error("button off");
	chk_deep_outs: assert property (deep_low_power_state_out |-> sleep_supply_on_n_out &&
		!module_reset_n_out && !power_state_on_out) else $error("deep outputs");
	chk_deep_kind: assert property (deep_low_power_state_out |-> $stable(sleep_kind_out))
		else $error("kind moved");
	chk_deep_wake: assert property ($fell(deep_low_power_state_out) |->
		!power_state_on_out && sleep_supply_on_n_out) else $error("wake not to sleep");
	chk_boot_policy: assert property ($fell(reset_in) |=> sleep_supply_on_n_out ==
		!(loss_policy_in == 2'h0 || (loss_policy_in == 2'h2 && last_state_on_in)))
		else $error("loss policy");
endmodule
`default_nettype wire

/* File: bench/mpc_supply_model.sv */
/* Carrier supply model: standby inverter, rail settling, released power good.
   Assumes the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module mpc_supply_model (
	input wire logic	clk_in,
	input wire logic	supply_n_in,
	input wire logic	hold_low_in,
	output logic	pg_out
);
	logic [3:0]	up_q = 4'h0;
	// Rails only rise while the inverted supply-on is low
	always @(posedge clk_in)
		up_q <= supply_n_in ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
	// Low until rails settle, then released so the divider reads good
	assign pg_out = !hold_low_in && up_q > 4'h8;
endmodule
`default_nettype wire

/* File: bench/tb_module_power_control.sv */
/* Bench for mpc_power_ctrl with a supply model and button driver.
   Assumes verilog/ on the include path. */
`timescale 1ns/1ps
`default_nettype none
module tb_module_power_control;
	logic		clk = 0, rst = 1, btn_n = 1, lst = 0, slp = 0, deep = 0, wake = 0, flt = 0, drop = 0;
	logic [1:0]	pol = 0, kind = 0;
	wire		mpg, sup_n, rst_n, on, dp, seq;
	wire [1:0]	ko;
	int		n_errors = 0, n_compared = 0, seed = 87, k;
	always #12.5 clk = ~clk;
	mpc_supply_model carrier (.clk_in(clk), .supply_n_in(sup_n), .hold_low_in(drop), .pg_out(mpg));
	mpc_power_ctrl #(.DEEP_DELAY_CYCLES(4)) dut (.ref_clk_in(clk), .reset_in(rst),
		.power_good_in(flt | mpg), .power_button_n_in(btn_n), .loss_policy_in(pol),
		.last_state_on_in(lst), .sleep_req_in(slp), .sleep_kind_in(kind), .deep_enable_in(deep),
		.wake_event_in(wake), .sleep_supply_on_n_out(sup_n), .module_reset_n_out(rst_n),
		.sequencing_en_out(seq), .deep_low_power_state_out(dp), .sleep_kind_out(ko),
		.power_state_on_out(on));
	task complete_run;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task check(input string nm, input logic [1:0] seen, input logic [1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wait_on(input logic v);
		for (k = 0; k < 99 && on !== v; k++)
			@(negedge clk);
		check("on", on, v);
		check("seq_en", seq, v);
		if (on !== v)
			complete_run;
	endtask
	// Held far beyond the synchroniser, as a debounced button would be
	task press;
		cyc(1);
		btn_n <= 0;
		cyc(6);
		btn_n <= 1;
		cyc(6);
	endtask
	task boot(input logic [1:0] p, input logic l);
		cyc(1);
		rst <= 1;
		pol <= p;
		lst <= l;
		cyc(10);
		rst <= 0;
		cyc(3);
		@(negedge clk);
		check("supply_n", sup_n, !(p == 0 || (p == 2 && l)));
		wait_on(p == 0 || (p == 2 && l));
	endtask
	initial begin
		for (int p = 0; p < 4; p++)
			boot(p[1:0], 1'($random(seed)));
		boot(2'h2, 1'b1);
		cyc(1);
		drop <= 1;
		cyc(5);
		@(negedge clk);
		check("reset_n", rst_n, 0);
		cyc(1);
		drop <= 0;
		wait_on(1);
		@(negedge clk);
		check("reset_n", rst_n, 1);
		press;
		wait_on(0);
		check("supply_n", sup_n, 1);
		press;
		wait_on(1);
		for (int s = 0; s < 3; s++) begin
			cyc(1);
			kind <= s[1:0];
			slp <= 1;
			deep <= 1;
			cyc(1);
			slp <= 0;
			cyc(12);
			@(negedge clk);
			check("deep", dp, 1);
			cyc(1);
			deep <= 0;
			if (s == 1) begin
				press;
			end else begin
				wake <= 1;
				cyc(1);
				wake <= 0;
				cyc(3);
			end
			@(negedge clk);
			check("deep", dp, 0);
			check("kind", ko, s[1:0]);
			check("on", on, 0);
			cyc(1);
			wake <= 1;
			cyc(1);
			wake <= 0;
			wait_on(1);
		end
		cyc(1);
		flt <= 1;
		boot(2'h0, 1'b0);
		complete_run;
	end
endmodule
bind mpc_power_ctrl mpc_power_ctrl_asserts chk (.*);
`default_nettype wire
